// [mbt_defs.svh]
// timing counts and reset values for the muxed bus turnaround block
`ifndef MBT_DEFS_SVH
`define MBT_DEFS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define MBT_CLK_PERIOD_NS 100
`define MBT_RD_IDLE_MIN   2
`define MBT_WBUF_DEPTH    4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define MBT_AD_RESET      32'h0000_0000

`endif

// [mbt_pkg.sv]
// types shared by the muxed bus turnaround block
package mbt_pkg;

  // ----------------------------------------------------------------
  // bus sequencer states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    MBT_IDLE    = 5'b00001,
    MBT_ADDR_LO = 5'b00010,
    MBT_ADDR_HI = 5'b00100,
    MBT_RD_DATA = 5'b01000,
    MBT_WR_DATA = 5'b10000
  } mbt_state_t;

  // ----------------------------------------------------------------
  // pad driver source
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MBT_DRV_Z    = 2'b00,
    MBT_DRV_ADDR = 2'b01,
    MBT_DRV_DATA = 2'b10
  } mbt_drv_t;

endpackage

// [mbt_write_buffer.sv]
// posted write queue for the muxed bus turnaround block
`timescale 1ns/1ns
`include "mbt_defs.svh"

module mbt_write_buffer
  import mbt_pkg::*;
#(
  parameter int AW    = 32,
  parameter int DW    = 32,
  parameter int DEPTH = `MBT_WBUF_DEPTH
) (
  // clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rst_b,
  // fill side
  input  wire logic          in_valid,
  output logic               in_ready,
  input  wire logic [AW-1:0] in_addr,
  input  wire logic [DW-1:0] in_data,
  // drain side
  output logic               out_valid,
  input  wire logic          out_ready,
  output logic [AW-1:0]      out_addr,
  output logic [DW-1:0]      out_data
);

  localparam int PW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("depth must be a power of two, at least 2");
  end

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [AW-1:0] mem_addr [DEPTH];
  logic [DW-1:0] mem_data [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0]   count;

  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;

  assign in_ready  = (count != (PW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_addr  = mem_addr[rd_ptr];
  assign out_data  = mem_data[rd_ptr];

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_addr[wr_ptr] <= in_addr;
      mem_data[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop)  rd_ptr <= rd_ptr + 1'b1;
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

endmodule // mbt_write_buffer

// [mbt_bus_turnaround.sv]
// processor-side sequencer of a multiplexed address/data bus
`timescale 1ns/1ns
`include "mbt_defs.svh"

module mbt_bus_turnaround
  import mbt_pkg::*;
#(
  parameter int AW         = 32,
  parameter int DW         = 32,
  parameter int WBUF_DEPTH = `MBT_WBUF_DEPTH,
  parameter int RD_IDLE    = `MBT_RD_IDLE_MIN
) (
  // clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rst_b,
  // read request from the core
  input  wire logic          rd_req,
  output logic               rd_ready,
  input  wire logic [AW-1:0] rd_addr,
  output logic               rd_done,
  output logic [DW-1:0]      rd_data,
  // store request from the core
  input  wire logic          st_req,
  output logic               st_ready,
  input  wire logic [AW-1:0] st_addr,
  input  wire logic [DW-1:0] st_data,
  // memory handshake
  input  wire logic          mem_ack,
  // multiplexed bus pins
  input  wire logic [31:0]   ad_in,
  output logic [31:0]        ad_out,
  output logic               ad_oe,
  output logic               addr_latch_enable,
  output logic               rd_strobe_b,
  output logic               wr_strobe_b,
  output logic               data_phase_enable
);

  if (AW != 32 || DW != 32) begin : g_bad_width
    $error("address and data must both be 32 bits on this bus");
  end
  if (RD_IDLE < 2) begin : g_bad_spacing
    $error("read spacing below two idle cycles is not served");
  end

  localparam int IW = $clog2(RD_IDLE + 1);

  // ----------------------------------------------------------------
  // write buffer
  // ----------------------------------------------------------------
  logic          wb_valid;
  logic          wb_ready;
  logic [AW-1:0] wb_addr;
  logic [DW-1:0] wb_data;

  mbt_write_buffer #(
    .AW    (AW),
    .DW    (DW),
    .DEPTH (WBUF_DEPTH)
  ) u_wbuf (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .in_valid  (st_req),
    .in_ready  (st_ready),
    .in_addr   (st_addr),
    .in_data   (st_data),
    .out_valid (wb_valid),
    .out_ready (wb_ready),
    .out_addr  (wb_addr),
    .out_data  (wb_data)
  );

  // ----------------------------------------------------------------
  // state and holding registers
  // ----------------------------------------------------------------
  mbt_state_t    state;
  mbt_state_t    next_state;
  logic          cyc_is_rd;
  logic [AW-1:0] cyc_addr;
  logic [DW-1:0] cyc_wdata;
  logic [IW-1:0] idle_cnt;
  logic          last_was_rd;
  mbt_drv_t      drv_sel;
  mbt_drv_t      next_drv_sel;

  // reads wait for the spacing; posted stores drain first to keep order
  wire rd_spaced  = !last_was_rd || (idle_cnt >= IW'(RD_IDLE));
  wire start_rd   = (state == MBT_IDLE) && rd_req && rd_spaced && !wb_valid;
  wire start_wr   = (state == MBT_IDLE) && wb_valid;
  wire in_data_ph = (state == MBT_RD_DATA) || (state == MBT_WR_DATA);
  wire cyc_end    = in_data_ph && mem_ack;

  assign wb_ready = start_wr;
  assign rd_ready = start_rd;

  // values the cycle will carry at the next edge
  wire           cyc_is_rd_next = start_rd ? 1'b1 : (start_wr ? 1'b0 : cyc_is_rd);
  wire [AW-1:0]  cyc_addr_next  = start_rd ? rd_addr : (start_wr ? wb_addr : cyc_addr);
  wire [DW-1:0]  cyc_wdata_next = start_wr ? wb_data : cyc_wdata;

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      MBT_IDLE: begin
        if (start_wr || start_rd) next_state = MBT_ADDR_LO;
      end
      MBT_ADDR_LO: begin
        next_state = MBT_ADDR_HI;
      end
      MBT_ADDR_HI: begin
        next_state = cyc_is_rd ? MBT_RD_DATA : MBT_WR_DATA;
      end
      MBT_RD_DATA: begin
        if (mem_ack) next_state = MBT_IDLE;
      end
      MBT_WR_DATA: begin
        if (mem_ack) next_state = MBT_IDLE;
      end
    endcase
  end

  // the driver source is registered so the pads never glitch between sources
  always_comb begin
    unique case (next_state)
      MBT_ADDR_LO: next_drv_sel = MBT_DRV_ADDR;
      MBT_ADDR_HI: next_drv_sel = cyc_is_rd ? MBT_DRV_Z : MBT_DRV_DATA;
      MBT_WR_DATA: next_drv_sel = MBT_DRV_DATA;
      MBT_RD_DATA: next_drv_sel = MBT_DRV_Z;
      default:     next_drv_sel = MBT_DRV_Z;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state   <= MBT_IDLE;
      drv_sel <= MBT_DRV_Z;
    end else begin
      state   <= next_state;
      drv_sel <= next_drv_sel;
    end
  end

  // capture of the cycle being run
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cyc_is_rd <= 1'b0;
      cyc_addr  <= `MBT_AD_RESET;
      cyc_wdata <= `MBT_AD_RESET;
    end else if (start_wr) begin
      cyc_is_rd <= 1'b0;
      cyc_addr  <= wb_addr;
      cyc_wdata <= wb_data;
    end else if (start_rd) begin
      cyc_is_rd <= 1'b1;
      cyc_addr  <= rd_addr;
    end
  end

  // idle cycles since the last bus cycle ended, read or write, and whether it was a read
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      last_was_rd <= 1'b0;
      idle_cnt    <= '0;
    end else if (cyc_end) begin
      last_was_rd <= cyc_is_rd;
      idle_cnt    <= '0;
    end else if (state == MBT_IDLE && idle_cnt < IW'(RD_IDLE)) begin
      idle_cnt <= idle_cnt + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  // the strobe covers the first address half only; the partner latches on its fall
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      addr_latch_enable <= 1'b0;
      rd_strobe_b       <= 1'b1;
      wr_strobe_b       <= 1'b1;
      data_phase_enable <= 1'b0;
      ad_out            <= `MBT_AD_RESET;
    end else begin
      addr_latch_enable <= (next_state == MBT_ADDR_LO);
      rd_strobe_b       <= !(next_state == MBT_RD_DATA || next_state == MBT_ADDR_HI)
                           || !cyc_is_rd_next;
      wr_strobe_b       <= !(next_state == MBT_WR_DATA);
      // enable only in the read data phase: never in address, write or idle
      data_phase_enable <= (next_state == MBT_RD_DATA);
      ad_out            <= (next_drv_sel == MBT_DRV_DATA) ? cyc_wdata_next
                                                          : cyc_addr_next;
    end
  end

  // one output enable for the whole bus, so drivers are one of three states
  assign ad_oe = (drv_sel != MBT_DRV_Z);

  // read data captured at the memory's acknowledge in the data phase
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rd_data <= `MBT_AD_RESET;
      rd_done <= 1'b0;
    end else begin
      rd_done <= (state == MBT_RD_DATA) && mem_ack;
      if ((state == MBT_RD_DATA) && mem_ack) rd_data <= ad_in;
    end
  end

endmodule // mbt_bus_turnaround

// [mbt_bus_turnaround_properties.sv]
// bus timing properties for the muxed bus turnaround block
`timescale 1ns/1ns

module mbt_bus_turnaround_chk (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // core side
  input wire logic rd_ready,
  input wire logic rd_done,
  // bus pins
  input wire logic ad_oe,
  input wire logic addr_latch_enable,
  input wire logic rd_strobe_b,
  input wire logic wr_strobe_b,
  input wire logic data_phase_enable
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_ale_drives_addr: assert property (addr_latch_enable |-> ad_oe)
    else $error("address not driven with latch strobe");
  a_addr_one_cycle: assert property ($rose(addr_latch_enable) |=> !addr_latch_enable)
    else $error("latch strobe longer than one cycle");
  a_read_floats: assert property ($fell(addr_latch_enable) && !rd_strobe_b |-> !ad_oe)
    else $error("bus still driven after read address");
  a_write_no_gap: assert property (
    $fell(addr_latch_enable) && rd_strobe_b |-> ad_oe ##1 ad_oe)
    else $error("float gap inside write");
  a_dpe_addr_low: assert property (addr_latch_enable |-> !data_phase_enable ##1 !data_phase_enable)
    else $error("data enable high in address phase");
  a_dpe_read_data: assert property (
    $fell(addr_latch_enable) && !rd_strobe_b |=> data_phase_enable)
    else $error("data enable missing in read data phase");
  a_dpe_write_low: assert property (!wr_strobe_b |-> !data_phase_enable)
    else $error("data enable high during write");
  a_dpe_bus_free: assert property (data_phase_enable |-> !rd_strobe_b && !ad_oe)
    else $error("data enable outside read data phase");
  a_read_spacing: assert property (rd_done |-> !rd_ready ##1 !rd_ready)
    else $error("read taken right after read");
endmodule // mbt_bus_turnaround_chk

bind mbt_bus_turnaround mbt_bus_turnaround_chk u_chk (
  .clk_sys           (clk_sys),
  .rst_b             (rst_b),
  .rd_ready          (rd_ready),
  .rd_done           (rd_done),
  .ad_oe             (ad_oe),
  .addr_latch_enable (addr_latch_enable),
  .rd_strobe_b       (rd_strobe_b),
  .wr_strobe_b       (wr_strobe_b),
  .data_phase_enable (data_phase_enable)
);

// [mbt_mem_model.sv]
// memory system model on the far side of the muxed bus
`timescale 1ns/1ns

module mbt_mem_model (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // device pins
  input  wire logic [31:0] ad_out,
  input  wire logic        ad_oe,
  input  wire logic        addr_latch_enable,
  input  wire logic        wr_strobe_b,
  input  wire logic        data_phase_enable,
  // memory side
  input  wire logic [3:0]  wait_n,
  output logic [31:0]      ad_in,
  output logic             mem_ack,
  output logic [31:0]      lat,
  output logic [31:0]      wr_addr,
  output logic [31:0]      wr_data,
  output logic [7:0]       wr_cnt
);
  localparam logic [31:0] RD_MIX = 32'h5a5a_0f0f;
  logic [31:0] last;
  logic [3:0]  cnt;
  wire         in_phase = data_phase_enable || !wr_strobe_b;
  // memory drives only while enabled; a released bus toggles so no stale value survives
  assign ad_in   = ad_oe ? ad_out : data_phase_enable ? (lat ^ RD_MIX) : ~last;
  assign mem_ack = in_phase && (cnt == wait_n);
  always_latch if (addr_latch_enable) lat <= ad_out;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt    <= 4'h0;
      last   <= 32'h0000_0000;
      wr_cnt <= 8'h00;
    end else begin
      last <= ad_in;
      cnt  <= in_phase ? cnt + 4'h1 : 4'h0;
      if (mem_ack && !wr_strobe_b) begin
        wr_addr <= lat;
        wr_data <= ad_in;
        wr_cnt  <= wr_cnt + 8'h01;
      end
    end
  end
endmodule // mbt_mem_model

// [mbt_bus_turnaround_test.sv]
// self-checking bench for the muxed bus turnaround block
`timescale 1ns/1ns
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin mismatches++; \
  $display("[FAIL] %0t %h %h", $time, (a), (b)); end end

module mbt_bus_turnaround_test;
  localparam logic [31:0] RD_MIX = 32'h5a5a_0f0f;
  logic        clk_sys = 1'b0;
  logic        rst_b   = 1'b0;
  logic        rd_req  = 1'b0;
  logic        st_req  = 1'b0;
  logic [31:0] rd_addr = 32'h0000_0000;
  logic [31:0] st_addr = 32'h0000_0000;
  logic [31:0] st_data = 32'h0000_0000;
  logic [3:0]  wait_n  = 4'h0;
  int          mismatches = 0;
  int          samples_checked = 0;
  wire logic [31:0] ad_in, ad_out, lat, wr_addr, wr_data, rd_data;
  wire logic [7:0]  wr_cnt;
  wire logic        rd_ready, rd_done, st_ready, mem_ack, ad_oe, ale, rd_sb, wr_sb, dpe;

  always #50 clk_sys = ~clk_sys;

  mbt_bus_turnaround uut (
    .clk_sys(clk_sys), .rst_b(rst_b), .rd_req(rd_req), .rd_ready(rd_ready),
    .rd_addr(rd_addr), .rd_done(rd_done), .rd_data(rd_data), .st_req(st_req),
    .st_ready(st_ready), .st_addr(st_addr), .st_data(st_data), .mem_ack(mem_ack),
    .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe), .addr_latch_enable(ale),
    .rd_strobe_b(rd_sb), .wr_strobe_b(wr_sb), .data_phase_enable(dpe));

  mbt_mem_model u_mem (
    .clk_sys(clk_sys), .rst_b(rst_b), .ad_out(ad_out), .ad_oe(ad_oe),
    .addr_latch_enable(ale), .wr_strobe_b(wr_sb), .data_phase_enable(dpe),
    .wait_n(wait_n), .ad_in(ad_in), .mem_ack(mem_ack), .lat(lat),
    .wr_addr(wr_addr), .wr_data(wr_data), .wr_cnt(wr_cnt));

  task automatic rd(input logic [31:0] a, input logic [3:0] w);
    int n;
    n = 0;
    @(posedge clk_sys);
    wait_n  <= w;
    rd_req  <= 1'b1;
    rd_addr <= a;
    do begin @(negedge clk_sys); n++; end while (rd_ready !== 1'b1 && n < 60);
    @(posedge clk_sys);
    rd_req <= 1'b0;
    do begin @(negedge clk_sys); n++; end while (rd_done !== 1'b1 && n < 120);
    `CHK(rd_data, a ^ RD_MIX)
    `CHK(lat, a)
  endtask

  task automatic t_reset;
    // bus must float until the first request
    repeat (3) begin
      @(negedge clk_sys);
      `CHK({ad_oe, dpe}, 2'b00)
    end
  endtask

  task automatic t_reads;
    // second read asked for at once, slow memory
    rd(32'h0000_1000, 4'h0);
    rd(32'hffff_fffc, 4'h3);
  endtask

  task automatic t_order;
    logic [7:0] c;
    @(posedge clk_sys);
    c = wr_cnt;
    st_req  <= 1'b1;
    st_addr <= 32'h0000_0040;
    st_data <= 32'hc3c3_3c3c;
    @(posedge clk_sys);
    st_req <= 1'b0;
    rd(32'h0000_0080, 4'h1);
    `CHK(wr_cnt, c + 8'h01)
    `CHK(wr_data, 32'hc3c3_3c3c)
  endtask

  task automatic t_fill;
    int acc;
    int n;
    logic [7:0] c;
    acc = 0;
    n = 0;
    @(posedge clk_sys);
    c = wr_cnt;
    wait_n <= 4'h9;
    st_req <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      st_addr <= 32'h0000_2000 + i * 4;
      st_data <= 32'h1111_0000 + i;
      @(negedge clk_sys);
      if (st_ready !== 1'b1) break;
      acc++;
      @(posedge clk_sys);
    end
    @(posedge clk_sys);
    st_req <= 1'b0;
    `CHK(acc, 5)
    do begin @(negedge clk_sys); n++; end while (wr_cnt != c + acc && n < 400);
    `CHK(wr_cnt, c + 8'(acc))
    `CHK(wr_addr, 32'h0000_2000 + (acc - 1) * 4)
    `CHK(wr_data, 32'h1111_0000 + acc - 1)
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_reset;
    t_reads;
    t_order;
    t_fill;
    wrap_up;
  end

  // watchdog at 3000 cycles: all tests need well under that
  initial begin
    #300000;
    mismatches++;
    wrap_up;
  end
endmodule // mbt_bus_turnaround_test
